/* rtl/adcsi_pkg.sv */
// constants, carriers and state type of the converter serial interface
package adcsi_pkg;

   // system clock
   localparam int CLK_HZ         = 25_000_000;
   localparam int CLK_PER_MS     = CLK_HZ / 1000;
   localparam int CLK_PER_US     = CLK_HZ / 1_000_000;

   // convert state durations
   localparam int CONV_LOW_MS    = 133;
   localparam int CONV_HIGH_MS   = 160;
   localparam int CONV_LOW_CYC   = CLK_PER_MS * CONV_LOW_MS;
   localparam int CONV_HIGH_CYC  = CLK_PER_MS * CONV_HIGH_MS;
   localparam int CONV_EXT_PER   = 20510;

   // data output limits and serial clock division
   localparam int DOUT_MAX_US    = 1670;
   localparam int DOUT_MAX_CYC   = CLK_PER_US * DOUT_MAX_US;
   localparam int SCK_DIV        = 8;
   localparam int FRAME_BITS     = 32;
   localparam int DOUT_TICKS     = SCK_DIV * FRAME_BITS;
   localparam int CONV_TICK_CYC  = DOUT_MAX_CYC / DOUT_TICKS;

   // field and counter widths
   localparam int RESULT_BITS    = 23;
   localparam int CHAN_BITS      = 5;
   localparam int CNT_W          = 22;
   localparam int TICK_W         = 8;

   // reset values
   localparam logic [CHAN_BITS-1:0] CHAN_RST = 5'h00;
   localparam logic                 MODE_RST = 1'h1;

   // result delivered by the modulator side
   typedef struct packed {
      logic                   sign_bit;
      logic [RESULT_BITS-1:0] mag;
   } adcsi_result_t;

   // 32-bit output word, busy flag first
   typedef struct packed {
      logic                   busy;
      logic                   dummy_bit;
      logic                   sign_bit;
      logic [RESULT_BITS-1:0] mag;
      logic [CHAN_BITS-1:0]   chan;
      logic                   parity;
   } adcsi_frame_t;

   // serial pin drives
   typedef struct packed {
      logic sdo_out;
      logic sdo_oe_n;
      logic sck_out;
      logic sck_oe_n;
   } adcsi_pins_t;

   typedef enum logic [1:0] {
      ST_CONVERT,
      ST_SLEEP,
      ST_DATA
   } adcsi_state_t;

endpackage : adcsi_pkg

/* rtl/adcsi_core.sv */
// conversion cycle sequencer and four-wire serial port of the converter
`timescale 1ns/1ps
module adcsi_core #(
   parameter int CONV_LOW  = adcsi_pkg::CONV_LOW_CYC,
   parameter int CONV_HIGH = adcsi_pkg::CONV_HIGH_CYC,
   parameter int CONV_EXT  = adcsi_pkg::CONV_EXT_PER
) (
   // clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  rst,
   // serial link pins
   input  wire logic                                  cs_n,
   input  wire logic                                  sck_in,
   input  wire logic                                  sdi,
   output adcsi_pkg::adcsi_pins_t                     pins,
   // rate selection and external oscillator
   input  wire logic                                  rejection_select_pin,
   input  wire logic                                  ext_osc_sel,
   input  wire logic                                  ext_osc_tick,
   // modulator side
   input  adcsi_pkg::adcsi_result_t                   result_in,
   output logic [adcsi_pkg::CHAN_BITS-1:0]            chan_sel,
   output logic                                       conv_start,
   output logic                                       busy
);

   adcsi_pkg::adcsi_state_t state;
   adcsi_pkg::adcsi_state_t next_state;
   adcsi_pkg::adcsi_frame_t frame;
   adcsi_pkg::adcsi_pins_t  next_pins;

   logic                                cs_s1;
   logic                                cs_s2;
   logic                                cs_s3;
   logic                                sck_s1;
   logic                                sck_s2;
   logic                                sck_s3;
   logic [1:0]                          por_cnt;
   logic                                int_mode;
   logic [adcsi_pkg::TICK_W-1:0]        tick_cnt;
   logic [adcsi_pkg::CNT_W-1:0]         conv_cnt;
   logic [2:0]                          phase;
   logic                                sck_lvl;
   logic [5:0]                          bit_cnt;
   logic [2:0]                          in_cnt;
   logic [adcsi_pkg::CHAN_BITS-1:0]     chan_shift;
   logic [adcsi_pkg::CHAN_BITS-1:0]     chan_pend;
   logic                                pend_valid;
   logic [adcsi_pkg::FRAME_BITS-1:0]    shreg;
   logic [adcsi_pkg::FRAME_BITS-1:0]    next_shreg;

   // pin edge detection, always past the second synchroniser stage
   wire cs_low   = ~cs_s2;
   wire cs_fall  = cs_s3 & ~cs_s2;
   wire cs_rise  = ~cs_s3 & cs_s2;
   wire ext_rise = ~sck_s3 & sck_s2 & cs_low;
   wire ext_fall = sck_s3 & ~sck_s2 & cs_low;
   wire por_done = (por_cnt == 2'h3);

   // mode is picked from the clock pin level at power-up and select fall
   wire next_int_mode = (!por_done && por_cnt == 2'h2) ? sck_s2 :
                        cs_fall ? sck_s2 : int_mode;

   // conversion clock: external oscillator or internal divider
   wire int_tick  = (tick_cnt == adcsi_pkg::TICK_W'(adcsi_pkg::CONV_TICK_CYC - 1));
   wire conv_tick = ext_osc_sel ? ext_osc_tick : int_tick;

   // convert length select and end of conversion
   wire [adcsi_pkg::CNT_W-1:0] conv_limit =
      ext_osc_sel          ? adcsi_pkg::CNT_W'(CONV_EXT - 1) :
      rejection_select_pin ? adcsi_pkg::CNT_W'(CONV_HIGH - 1) :
                             adcsi_pkg::CNT_W'(CONV_LOW - 1);
   wire conv_step = ext_osc_sel ? ext_osc_tick : 1'b1;
   wire conv_done = (state == adcsi_pkg::ST_CONVERT) && conv_step && (conv_cnt == conv_limit);

   // internal serial clock: eight conversion ticks per period
   wire run_int  = int_mode && (state == adcsi_pkg::ST_DATA) && cs_low;
   wire int_rise = run_int && conv_tick && (phase == 3'h3);
   wire int_fall = run_int && conv_tick && (phase == 3'h7);

   // serial edges of the active mode
   wire rise_ev  = int_mode ? int_rise : ext_rise;
   wire fall_ev  = int_mode ? int_fall : (ext_fall && state == adcsi_pkg::ST_DATA);
   // mode of this select is used, so an external frame never starts without a rise
   wire start_dt = (state == adcsi_pkg::ST_SLEEP) && cs_low &&
                   (next_int_mode || ext_rise);
   wire in_data  = (state == adcsi_pkg::ST_DATA) && cs_low;
   wire capture  = (in_data || start_dt) && rise_ev && (in_cnt < 3'h5);
   wire last_fall = fall_ev && (bit_cnt == 6'(adcsi_pkg::FRAME_BITS - 1));
   wire abort    = (state == adcsi_pkg::ST_DATA) && cs_rise;
   wire conv_go  = (state == adcsi_pkg::ST_DATA) && (next_state == adcsi_pkg::ST_CONVERT);

   // output word from the finished conversion
   assign frame = '{busy:      1'b0,
                    dummy_bit: 1'b0,
                    sign_bit:  result_in.sign_bit,
                    mag:       result_in.mag,
                    chan:      chan_sel,
                    parity:    ^{result_in.sign_bit, result_in.mag, chan_sel}};

   // state sequencing
   always_comb
   begin
      next_state = state;
      case (state)
         adcsi_pkg::ST_CONVERT:
            if (conv_done)
               next_state = adcsi_pkg::ST_SLEEP;
         adcsi_pkg::ST_SLEEP:
            if (start_dt)
               next_state = adcsi_pkg::ST_DATA;
         adcsi_pkg::ST_DATA:
            if (abort || last_fall || cs_s2)
               next_state = adcsi_pkg::ST_CONVERT;
         default:
            next_state = adcsi_pkg::ST_CONVERT;
      endcase
   end

   // shift register: load at end of conversion, shift on falling edge
   always_comb
   begin
      next_shreg = shreg;
      if (conv_done)
         next_shreg = frame;
      else if (in_data && fall_ev)
         next_shreg = {shreg[adcsi_pkg::FRAME_BITS-2:0], 1'b0};
   end

   // pin drives for the next cycle
   always_comb
   begin
      next_pins.sdo_oe_n = cs_s2;
      case (next_state)
         adcsi_pkg::ST_CONVERT: next_pins.sdo_out = 1'b1;
         adcsi_pkg::ST_SLEEP:   next_pins.sdo_out = 1'b0;
         adcsi_pkg::ST_DATA:    next_pins.sdo_out = next_shreg[adcsi_pkg::FRAME_BITS-1];
         default:    next_pins.sdo_out = 1'b1;
      endcase
      next_pins.sck_oe_n = ~(next_int_mode && cs_low);
      next_pins.sck_out  = (next_state == adcsi_pkg::ST_DATA) && next_int_mode &&
                           (int_rise ? 1'b1 : int_fall ? 1'b0 : sck_lvl);
   end

   // input synchronisers, idle high like a pulled-up pin
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cs_s1  <= 1'b1;
         cs_s2  <= 1'b1;
         cs_s3  <= 1'b1;
         sck_s1 <= 1'b1;
         sck_s2 <= 1'b1;
         sck_s3 <= 1'b1;
      end
      else
      begin
         cs_s1  <= cs_n;
         cs_s2  <= cs_s1;
         cs_s3  <= cs_s2;
         sck_s1 <= sck_in;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
      end
   end

   // power-up mode capture and mode register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         por_cnt  <= 2'h0;
         int_mode <= adcsi_pkg::MODE_RST;
      end
      else
      begin
         if (!por_done)
            por_cnt <= por_cnt + 2'h1;
         int_mode <= next_int_mode;
      end
   end

   // internal conversion clock divider
   always_ff @(posedge clk)
   begin
      if (rst || int_tick)
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + adcsi_pkg::TICK_W'(1);
   end

   // convert duration counter
   always_ff @(posedge clk)
   begin
      if (rst || state != adcsi_pkg::ST_CONVERT)
         conv_cnt <= '0;
      else if (conv_step)
         conv_cnt <= conv_cnt + adcsi_pkg::CNT_W'(1);
   end

   // main state and serial clock phase
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state   <= adcsi_pkg::ST_CONVERT;
         phase   <= 3'h0;
         sck_lvl <= 1'b0;
      end
      else
      begin
         state   <= next_state;
         sck_lvl <= next_pins.sck_out;
         if (next_state != adcsi_pkg::ST_DATA)
            phase <= 3'h0;
         else if (run_int && conv_tick)
            phase <= phase + 3'h1;
      end
   end

   // output bit counter and shift register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bit_cnt <= 6'h00;
         shreg   <= '0;
      end
      else
      begin
         shreg <= next_shreg;
         if (next_state != adcsi_pkg::ST_DATA)
            bit_cnt <= 6'h00;
         else if (in_data && fall_ev)
            bit_cnt <= bit_cnt + 6'h01;
      end
   end

   // channel bits in on rising edges, committed at the last address bit
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         in_cnt     <= 3'h0;
         chan_shift <= adcsi_pkg::CHAN_RST;
         chan_pend  <= adcsi_pkg::CHAN_RST;
         pend_valid <= 1'b0;
      end
      else if (conv_go)
      begin
         in_cnt     <= 3'h0;
         pend_valid <= 1'b0;
      end
      else if (capture)
      begin
         in_cnt     <= in_cnt + 3'h1;
         chan_shift <= {chan_shift[adcsi_pkg::CHAN_BITS-2:0], sdi};
         if (in_cnt == 3'h4)
         begin
            chan_pend  <= {chan_shift[adcsi_pkg::CHAN_BITS-2:0], sdi};
            pend_valid <= 1'b1;
         end
      end
   end

   // conversion start, channel hand-over and status outputs
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         chan_sel   <= adcsi_pkg::CHAN_RST;
         conv_start <= 1'b0;
         busy       <= 1'b1;
         pins       <= '{sdo_out: 1'b1, sdo_oe_n: 1'b1, sck_out: 1'b0, sck_oe_n: 1'b1};
      end
      else
      begin
         conv_start <= conv_go;
         busy       <= (next_state == adcsi_pkg::ST_CONVERT);
         pins       <= next_pins;
         if (conv_go && pend_valid)
            chan_sel <= chan_pend;
      end
   end

endmodule : adcsi_core

/* testbench/adcsi_core_chk.sv */
// concurrent checks on the converter serial port pins and status outputs
`timescale 1ns/1ps
module adcsi_core_chk (
   // clock and reset
   input wire logic                               clk,
   input wire logic                               rst,
   // link
   input wire logic                               cs_n,
   input wire logic                               sck_in,
   input adcsi_pkg::adcsi_pins_t                  pins,
   // status
   input wire logic [adcsi_pkg::CHAN_BITS-1:0]    chan_sel,
   input wire logic                               conv_start,
   input wire logic                               busy
);
   localparam int HALF = 4 * adcsi_pkg::CONV_TICK_CYC + 8;
   logic [11:0] half_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // cycles since the generated clock last moved
   always_ff @(posedge clk)
      half_cnt <= ($changed(pins.sck_out) || busy || pins.sck_oe_n) ? 12'h000 : half_cnt + 12'h001;
   sequence s_desel; cs_n [*4]; endsequence
   sequence s_sel_busy; (!cs_n && busy) [*5]; endsequence
   property p_hiz; s_desel |-> pins.sdo_oe_n; endproperty
   property p_sck_rel; s_desel |-> pins.sck_oe_n; endproperty
   property p_eoc_hi; s_sel_busy |-> pins.sdo_out && !pins.sdo_oe_n; endproperty
   property p_eoc_lo; ($fell(busy) && !cs_n) |-> ##[0:4] !pins.sdo_out; endproperty
   property p_start; $rose(busy) |-> conv_start ##1 !conv_start; endproperty
   property p_start_busy; conv_start |-> busy; endproperty
   property p_chan; $changed(chan_sel) |-> ##[0:1] busy; endproperty
   property p_sck_half; !pins.sck_oe_n |-> half_cnt <= HALF; endproperty
   property p_sdo_edge;
      ($changed(pins.sdo_out) && !pins.sdo_oe_n && $past(!pins.sdo_oe_n) && pins.sck_oe_n
         && !busy && !$past(busy)) |-> !$past(sck_in, 1) && !$past(sck_in, 2)
         && ($past(sck_in, 3) || $past(sck_in, 4) || $past(sck_in, 5));
   endproperty
   a_hiz: assert property (p_hiz) else $error("sdo driven while deselected");
   a_sck_rel: assert property (p_sck_rel) else $error("sck driven while deselected");
   a_eoc_hi: assert property (p_eoc_hi) else $error("busy flag not on sdo");
   a_eoc_lo: assert property (p_eoc_lo) else $error("sdo not low after conversion");
   a_start: assert property (p_start) else $error("no start pulse");
   a_start_busy: assert property (p_start_busy) else $error("start outside convert");
   a_chan: assert property (p_chan) else $error("channel changed outside start");
   a_sck_half: assert property (p_sck_half) else $error("sck half period too long");
   a_sdo_edge: assert property (p_sdo_edge) else $error("sdo moved off falling sck");
endmodule : adcsi_core_chk

bind adcsi_core adcsi_core_chk u_chk (.clk(clk), .rst(rst), .cs_n(cs_n), .sck_in(sck_in),
   .pins(pins), .chan_sel(chan_sel), .conv_start(conv_start), .busy(busy));

/* testbench/adcsi_host.sv */
// bus master model driving the converter link
`timescale 1ns/1ps
module adcsi_host (
   // clock
   input  wire logic clk,
   // link wires
   input  wire logic sdo,
   output logic      cs_n,
   output logic      sck,
   output logic      sck_en,
   output logic      sdi
);
   // idle: deselected, clock driven low
   initial
   begin
      cs_n = 1'b1;
      sck = 1'b0;
      sck_en = 1'b1;
      sdi = 1'b0;
   end
   // select; internal mode leaves the clock to the pull-up
   task select(input logic internal);
      @(negedge clk);
      sck_en = !internal;
      sck = 1'b0;
      @(negedge clk);
      cs_n = 1'b0;
   endtask : select
   // deselect and take the clock back once the device let go
   task deselect();
      cs_n = 1'b1;
      sdi = ~sdi;
      repeat (4) @(negedge clk);
      sck_en = 1'b1;
   endtask : deselect
   // n clock periods; fewer than 32 ends in an abort
   task frame(input int n, input logic [4:0] addr, output logic [31:0] got);
      int i;
      got = 32'h0;
      if (cs_n)
         select(1'b0);
      repeat (6) @(negedge clk);
      for (i = 0; i < n; i++)
      begin
         sdi = (i < 5) ? addr[4-i] : ~sdi;
         repeat (4) @(negedge clk);
         sck = 1'b1;
         got = {got[30:0], sdo};
         repeat (4) @(negedge clk);
         sck = 1'b0;
      end
      repeat (6) @(negedge clk);
      if (n != 32)
         deselect();
   endtask : frame
endmodule : adcsi_host

/* testbench/adcsi_core_tb.sv */
// self-checking bench of the converter serial port
`timescale 1ns/1ps
module adcsi_core_tb;
   localparam int CL = 200;
   localparam int CH = 300;
   localparam int CE = 50;
   logic                               clk, rst, sck_in, sdo_w, rs, eosc;
   logic                               h_cs, h_sck, h_en, h_sdi, conv_start, busy;
   logic [1:0]                         tc = 2'h0;
   logic [31:0]                        got;
   logic [adcsi_pkg::CHAN_BITS-1:0]    chan_sel;
   adcsi_pkg::adcsi_pins_t             pins;
   adcsi_pkg::adcsi_result_t           res;
   int                                 fails, total_checks;
   // wire resolution: sck pulled up, floating sdo toggles
   assign sck_in = !pins.sck_oe_n ? pins.sck_out : (h_en ? h_sck : 1'b1);
   assign sdo_w = !pins.sdo_oe_n ? pins.sdo_out : tc[0];
   // clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // oscillator ticks every fourth cycle
   always @(negedge clk) tc <= tc + 2'h1;
   adcsi_host h (.clk(clk), .sdo(sdo_w), .cs_n(h_cs), .sck(h_sck), .sck_en(h_en), .sdi(h_sdi));
   adcsi_core #(.CONV_LOW(CL), .CONV_HIGH(CH), .CONV_EXT(CE)) dut (.clk(clk), .rst(rst),
      .cs_n(h_cs), .sck_in(sck_in), .sdi(h_sdi), .pins(pins), .rejection_select_pin(rs),
      .ext_osc_sel(eosc), .ext_osc_tick(tc == 2'h3), .result_in(res), .chan_sel(chan_sel),
      .conv_start(conv_start), .busy(busy));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
         fails++;
      end
   endtask : chk
   task wait_busy(input logic v, output int n);
      n = 0;
      while (busy !== v && n < 60000)
      begin
         @(negedge clk);
         n++;
      end
      chk("busy", busy, v);
   endtask : wait_busy
   task conv_len(input int exp);
      int n;
      wait_busy(1'b1, n);
      wait_busy(1'b0, n);
      chk("conv len", n > exp - 16 && n <= exp + 2, 1'b1);
   endtask : conv_len
   function logic [31:0] exp_frame(input logic [4:0] ch);
      logic [31:0] f;
      f = {2'b00, res.sign_bit, res.mag, ch, 1'b0};
      f[0] = ^f[31:1];
      return f;
   endfunction : exp_frame
   task t_frame();
      int n;
      h.select(1'b0);
      repeat (6) @(negedge clk);
      chk("eoc busy", sdo_w, 1'b1);
      wait_busy(1'b0, n);
      repeat (5) @(negedge clk);
      chk("eoc done", sdo_w, 1'b0);
      h.frame(32, 5'h15, got);
      chk("frame", got, exp_frame(adcsi_pkg::CHAN_RST));
      chk("sdo end", sdo_w, 1'b1);
      chk("chan", chan_sel, 5'h15);
      conv_len(CL);
      h.deselect();
      chk("hiz", pins.sdo_oe_n, 1'b1);
   endtask : t_frame
   task t_abort();
      rs = 1'b1;
      h.frame(3, 5'h0A, got);
      chk("abort busy", busy, 1'b1);
      chk("kept chan", chan_sel, 5'h15);
      conv_len(CH);
      eosc = 1'b1;
      h.frame(6, 5'h0A, got);
      chk("part frame", got[5:0], exp_frame(5'h15) >> 26);
      chk("new chan", chan_sel, 5'h0A);
      conv_len(CE * 4);
      eosc = 1'b0;
   endtask : t_abort
   task t_internal();
      int n, rises, t0, t1;
      logic prev;
      rises = 0;
      n = 0;
      h.select(1'b1);
      prev = sck_in;
      while (busy !== 1'b1 && n < 60000)
      begin
         @(negedge clk);
         n++;
         if (sck_in && !prev)
         begin
            got = {got[30:0], sdo_w};
            if (rises == 0)
               t0 = n;
            t1 = n;
            rises++;
         end
         prev = sck_in;
      end
      chk("rises", rises, 32);
      chk("period", (t1 - t0) / 31, 8 * adcsi_pkg::CONV_TICK_CYC);
      chk("int frame", got, exp_frame(5'h0A));
      h.deselect();
   endtask : t_internal
   task test_done();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   // watchdog
   initial
   begin
      #(40 * 70000);
      fails++;
      test_done();
   end
   // main sequence
   initial
   begin
      fails = 0;
      total_checks = 0;
      rs = 1'b0;
      eosc = 1'b0;
      res = {1'b1, 23'h5A3C1F};
      rst = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      t_frame();
      t_abort();
      t_internal();
      test_done();
   end
endmodule : adcsi_core_tb
